// [core/tw_cfg.svh]
// offsets, field positions, reset values and fixed tops of the 16-bit waveform timer
`ifndef TW_CFG_SVH
`define TW_CFG_SVH

// ********************************
// register indices (byte address = index * 4)
// ********************************
`define TW_IDX_CTRL_A 10'h080
`define TW_IDX_CTRL_B 10'h081
`define TW_IDX_COUNT 10'h084
`define TW_IDX_CAPTURE 10'h086
`define TW_IDX_CMP_A 10'h088
`define TW_IDX_CMP_B 10'h08A
`define TW_IDX_STATUS 10'h090
`define TW_IDX_MASK 10'h091
`define TW_IDX_PORT 10'h092

// ********************************
// field positions
// ********************************
`define TW_COM_A_LSB 6
`define TW_COM_B_LSB 4
`define TW_NC_BIT 7
`define TW_ES_BIT 6
`define TW_WGM_HI_LSB 3
`define TW_ST_OVF 0
`define TW_ST_CMP_A 1
`define TW_ST_CMP_B 2
`define TW_ST_CAP 3
`define TW_PT_DIR_A 0
`define TW_PT_DIR_B 1
`define TW_PT_OUT_A 2
`define TW_PT_OUT_B 3

// ********************************
// values
// ********************************
`define TW_RST_CTRL 8'h00
`define TW_TOP_8 16'h00FF
`define TW_TOP_9 16'h01FF
`define TW_TOP_10 16'h03FF
`define TW_TOP_MAX 16'hFFFF
`define TW_DIV_8 10'h007
`define TW_DIV_64 10'h03F
`define TW_DIV_256 10'h0FF
`define TW_DIV_1024 10'h3FF
`define TW_RESP_OKAY 2'h0
`define TW_RESP_SLVERR 2'h2

`endif

// [core/tw_pkg.sv]
// types and mode decoding of the 16-bit waveform timer
`include "tw_cfg.svh"

package tw_pkg;

    typedef enum logic [2:0] {TW_NORMAL, TW_CTC, TW_FAST, TW_PHASE, TW_PFC, TW_RSVD} tw_class_t;
    typedef enum logic [1:0] {TW_SRC_FIXED, TW_SRC_CMP_A, TW_SRC_CAP} tw_src_t;

    typedef struct packed {
        tw_class_t cls;
        tw_src_t src;
        logic [15:0] fixed_top;
    } tw_mode_t;

    function automatic tw_mode_t tw_decode(input logic [3:0] wgm);
        tw_mode_t m;
        m.cls = TW_NORMAL;
        m.src = TW_SRC_FIXED;
        m.fixed_top = `TW_TOP_MAX;
        unique case (wgm)
            4'h0: m.cls = TW_NORMAL;
            4'h1: m = '{TW_PHASE, TW_SRC_FIXED, `TW_TOP_8};
            4'h2: m = '{TW_PHASE, TW_SRC_FIXED, `TW_TOP_9};
            4'h3: m = '{TW_PHASE, TW_SRC_FIXED, `TW_TOP_10};
            4'h4: m = '{TW_CTC, TW_SRC_CMP_A, `TW_TOP_MAX};
            4'h5: m = '{TW_FAST, TW_SRC_FIXED, `TW_TOP_8};
            4'h6: m = '{TW_FAST, TW_SRC_FIXED, `TW_TOP_9};
            4'h7: m = '{TW_FAST, TW_SRC_FIXED, `TW_TOP_10};
            4'h8: m = '{TW_PFC, TW_SRC_CAP, `TW_TOP_MAX};
            4'h9: m = '{TW_PFC, TW_SRC_CMP_A, `TW_TOP_MAX};
            4'hA: m = '{TW_PHASE, TW_SRC_CAP, `TW_TOP_MAX};
            4'hB: m = '{TW_PHASE, TW_SRC_CMP_A, `TW_TOP_MAX};
            4'hC: m = '{TW_CTC, TW_SRC_CAP, `TW_TOP_MAX};
            4'hD: m.cls = TW_RSVD;
            4'hE: m = '{TW_FAST, TW_SRC_CAP, `TW_TOP_MAX};
            4'hF: m = '{TW_FAST, TW_SRC_CMP_A, `TW_TOP_MAX};
        endcase
        return m;
    endfunction

endpackage

// [core/tw_chan_if.sv]
// per-channel link between the timer core and a waveform output unit
interface tw_chan_if;
    import tw_pkg::*;
    tw_class_t cls;
    logic [3:0] wgm;
    logic [1:0] com;
    logic match;
    logic cmp_is_top;
    logic bottom;
    logic down;
    logic wave;
    logic conn;
    modport core (output cls, wgm, com, match, cmp_is_top, bottom, down, input wave, conn);
    modport chan (input cls, wgm, com, match, cmp_is_top, bottom, down, output wave, conn);
endinterface

// [core/tw_prescale.sv]
// timer clock selection: prescaler taps and synchronised external clock pin
`include "tw_cfg.svh"
module tw_prescale
    import tw_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [2:0] clock_source_select,
    input wire logic ext_clock_pin,
    output logic tick
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic [9:0] div;
    } tw_ps_t;

    tw_ps_t q, d;

    function automatic logic tap(input logic [9:0] div, input logic [9:0] m);
        return (div & m) == m;
    endfunction

    always_comb begin
        d = q;
        d.s1 = ext_clock_pin;
        d.s2 = q.s1;
        d.prev = q.s2;
        // free running divider: not restarted when the clock source select changes
        d.div = q.div + 10'h001;
        unique case (clock_source_select)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = tap(q.div, `TW_DIV_8);
            3'h3: tick = tap(q.div, `TW_DIV_64);
            3'h4: tick = tap(q.div, `TW_DIV_256);
            3'h5: tick = tap(q.div, `TW_DIV_1024);
            3'h6: tick = q.prev & ~q.s2;
            3'h7: tick = ~q.prev & q.s2;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

endmodule

// [core/tw_wave_chan.sv]
// one compare output unit: waveform flip-flop and pin takeover decision
module tw_wave_chan
    import tw_pkg::*;
#(
    parameter bit IS_A = 1'b1
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    tw_chan_if.chan ch
);

    typedef struct packed {
        logic wave;
    } tw_wc_t;

    tw_wc_t q, d;
    logic tog_ok;

    always_comb begin
        d = q;
        tog_ok = 1'b0;
        unique case (ch.cls)
            TW_NORMAL, TW_CTC: begin
                if (ch.match) begin
                    unique case (ch.com)
                        2'h0: d.wave = q.wave;
                        2'h1: d.wave = ~q.wave;
                        2'h2: d.wave = 1'b0;
                        2'h3: d.wave = 1'b1;
                    endcase
                end
                tog_ok = 1'b1;
            end
            TW_FAST: begin
                tog_ok = IS_A && (ch.wgm == 4'hE || ch.wgm == 4'hF);
                if (ch.com[1]) begin
                    // bottom wins: a match at top is dropped
                    if (ch.bottom) begin
                        d.wave = ~ch.com[0];
                    end else if (ch.match && !ch.cmp_is_top) begin
                        d.wave = ch.com[0];
                    end
                end else if (ch.com[0] && tog_ok && ch.match) begin
                    d.wave = ~q.wave;
                end
            end
            TW_PHASE, TW_PFC: begin
                tog_ok = IS_A && (ch.wgm == 4'h9 || ch.wgm == 4'hB);
                if (ch.com[1] && ch.match) begin
                    d.wave = ch.com[0] ^ ch.down;
                end else if (ch.com[0] && tog_ok && ch.match) begin
                    d.wave = ~q.wave;
                end
            end
            TW_RSVD: tog_ok = 1'b0;
        endcase
        // 01 without a toggle mode leaves the port in charge
        ch.conn = (ch.cls != TW_RSVD) && (ch.com[1] || (ch.com[0] && tog_ok));
        ch.wave = q.wave;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

endmodule

// [core/tw_timer16.sv]
// 16-bit waveform timer: registers, counter, capture and compare output control
//
// How it works
// - nonzero compare mode hands pin to waveform, 01 only where it toggles, none in mode 13
// - pin driver follows direction bit only
// - non-PWM: disconnect, toggle, clear, set on match
// - fast PWM: 10 non-inverting, 11 inverting
// - fast PWM 01 toggles A in 14/15
// - fast PWM 10/11 match at top ignored
// - dual slope: 10 clear up, set down
// - dual slope 01 toggles A in 9/11
// - mode joins two control register fields
// - mode 0: top max, immediate, overflow max
// - clear-on-match: top A or capture
// - phase correct: load at top, overflow bottom
// - freq correct: load and overflow at bottom
// - clock select: stop, prescale, external edge
// - capture pin ignored when capture is top
`include "tw_cfg.svh"
module tw_timer16
    import tw_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic capture_pin,
    input wire logic ext_clock_pin,
    output logic wave_out_a,
    output logic wave_out_a_oe_b,
    output logic wave_out_b,
    output logic wave_out_b_oe_b,
    output logic irq
);

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [3:0] wgm;
        logic noise_en;
        logic edge_sel;
        logic [2:0] cs;
        logic [15:0] cnt;
        logic down;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] buf_a;
        logic [15:0] buf_b;
        logic [15:0] cap;
        logic [3:0] status;
        logic [3:0] mask;
        logic [3:0] port;
        logic cap_s1, cap_s2;
        logic filt;
        logic [1:0] filt_cnt;
        logic cap_prev;
        logic aw_got, w_got;
        logic [9:0] aw_idx;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tw_state_t;

    tw_state_t q, d;

    tw_mode_t md;
    logic tick;
    logic [15:0] top;
    logic at_top, at_zero;
    logic tov_ev, load_ev;
    logic cap_in, cap_edge;
    logic [3:0] st_set, st_clr;
    logic [31:0] rd_word;

    tw_chan_if ch_a();
    tw_chan_if ch_b();

    // ********************************
    // helpers
    // ********************************
    function automatic logic hit(input logic [9:0] idx);
        unique case (idx)
            `TW_IDX_CTRL_A, `TW_IDX_CTRL_B, `TW_IDX_COUNT, `TW_IDX_CAPTURE,
            `TW_IDX_CMP_A, `TW_IDX_CMP_B, `TW_IDX_STATUS, `TW_IDX_MASK,
            `TW_IDX_PORT: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // 16-bit registers take byte lanes 0 and 1 independently
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    // ********************************
    // submodules
    // ********************************
    tw_prescale u_ps (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .clock_source_select(q.cs),
        .ext_clock_pin(ext_clock_pin),
        .tick(tick)
    );

    tw_wave_chan #(.IS_A(1'b1)) u_ch_a (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .ch(ch_a.chan)
    );

    tw_wave_chan #(.IS_A(1'b0)) u_ch_b (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .ch(ch_b.chan)
    );

    // ********************************
    // mode, top and channel links
    // ********************************
    always_comb begin
        md = tw_decode(q.wgm);
        unique case (md.src)
            TW_SRC_FIXED: top = md.fixed_top;
            TW_SRC_CMP_A: top = q.cmp_a;
            TW_SRC_CAP: top = q.cap;
            default: top = `TW_TOP_MAX;
        endcase
        at_top = q.cnt == top;
        at_zero = q.cnt == 16'h0000;
    end

    assign ch_a.cls = md.cls;
    assign ch_a.wgm = q.wgm;
    assign ch_a.com = q.com_a;
    assign ch_a.match = tick && (q.cnt == q.cmp_a);
    assign ch_a.cmp_is_top = q.cmp_a == top;
    assign ch_a.bottom = tick && at_top;
    assign ch_a.down = q.down;
    assign ch_b.cls = md.cls;
    assign ch_b.wgm = q.wgm;
    assign ch_b.com = q.com_b;
    assign ch_b.match = tick && (q.cnt == q.cmp_b);
    assign ch_b.cmp_is_top = q.cmp_b == top;
    assign ch_b.bottom = tick && at_top;
    assign ch_b.down = q.down;

    // ********************************
    // pins and interrupt
    // ********************************
    assign wave_out_a = ch_a.conn ? ch_a.wave : q.port[`TW_PT_OUT_A];
    assign wave_out_b = ch_b.conn ? ch_b.wave : q.port[`TW_PT_OUT_B];
    assign wave_out_a_oe_b = ~q.port[`TW_PT_DIR_A];
    assign wave_out_b_oe_b = ~q.port[`TW_PT_DIR_B];
    assign irq = |(q.status & q.mask);

    // ********************************
    // bus handshakes
    // ********************************
    assign s_axi_awready = ce && !q.aw_got && !q.bvalid;
    assign s_axi_wready = ce && !q.w_got && !q.bvalid;
    assign s_axi_arready = ce && !q.rvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    // ********************************
    // next state
    // ********************************
    always_comb begin
        d = q;
        tov_ev = 1'b0;
        load_ev = 1'b0;
        st_set = 4'h0;
        st_clr = 4'h0;
        if (tick) begin
            unique case (md.cls)
                TW_NORMAL, TW_CTC, TW_RSVD: begin
                    d.cnt = (md.cls == TW_CTC && at_top) ? 16'h0000 : q.cnt + 16'h0001;
                    tov_ev = q.cnt == `TW_TOP_MAX;
                end
                TW_FAST: begin
                    d.cnt = at_top ? 16'h0000 : q.cnt + 16'h0001;
                    tov_ev = at_top;
                    load_ev = at_top;
                end
                TW_PHASE, TW_PFC: begin
                    if (!q.down && at_top) begin
                        d.down = 1'b1;
                        d.cnt = q.cnt - 16'h0001;
                    end else if (q.down && at_zero) begin
                        d.down = 1'b0;
                        d.cnt = q.cnt + 16'h0001;
                    end else begin
                        d.cnt = q.down ? q.cnt - 16'h0001 : q.cnt + 16'h0001;
                    end
                    tov_ev = q.down && at_zero;
                    if (md.cls == TW_PHASE) begin
                        load_ev = !q.down && at_top;
                    end else begin
                        load_ev = q.down && at_zero;
                    end
                end
            endcase
        end
        d.down = d.down && (md.cls == TW_PHASE || md.cls == TW_PFC);
        if (md.cls == TW_NORMAL || md.cls == TW_CTC || md.cls == TW_RSVD) begin
            d.cmp_a = q.buf_a;
            d.cmp_b = q.buf_b;
        end else if (load_ev) begin
            d.cmp_a = q.buf_a;
            d.cmp_b = q.buf_b;
        end
        // capture input: two-flop sync, optional 4-sample filter
        d.cap_s1 = capture_pin;
        d.cap_s2 = q.cap_s1;
        if (q.cap_s2 == q.filt) begin
            d.filt_cnt = 2'h0;
        end else begin
            d.filt_cnt = q.filt_cnt + 2'h1;
            if (q.filt_cnt == 2'h3) begin
                d.filt = q.cap_s2;
                d.filt_cnt = 2'h0;
            end
        end
        cap_in = q.noise_en ? q.filt : q.cap_s2;
        d.cap_prev = cap_in;
        cap_edge = q.edge_sel ? (cap_in && !q.cap_prev) : (!cap_in && q.cap_prev);
        if (md.src == TW_SRC_CAP) begin
            // pin disconnected; the flag marks top instead
            st_set[`TW_ST_CAP] = tick && at_top;
        end else if (cap_edge) begin
            d.cap = q.cnt;
            st_set[`TW_ST_CAP] = 1'b1;
        end
        st_set[`TW_ST_OVF] = tov_ev;
        st_set[`TW_ST_CMP_A] = ch_a.match;
        st_set[`TW_ST_CMP_B] = ch_b.match;
        // write channel: address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_got = 1'b1;
            d.aw_idx = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = hit(q.aw_idx) ? `TW_RESP_OKAY : `TW_RESP_SLVERR;
            if (q.wstrb[0]) begin
                unique case (q.aw_idx)
                    `TW_IDX_CTRL_A: begin
                        d.com_a = q.wdata[`TW_COM_A_LSB +: 2];
                        d.com_b = q.wdata[`TW_COM_B_LSB +: 2];
                        d.wgm[1:0] = q.wdata[1:0];
                    end
                    `TW_IDX_CTRL_B: begin
                        d.noise_en = q.wdata[`TW_NC_BIT];
                        d.edge_sel = q.wdata[`TW_ES_BIT];
                        d.wgm[3:2] = q.wdata[`TW_WGM_HI_LSB +: 2];
                        d.cs = q.wdata[2:0];
                    end
                    `TW_IDX_STATUS: st_clr = q.wdata[3:0];
                    `TW_IDX_MASK: d.mask = q.wdata[3:0];
                    `TW_IDX_PORT: d.port = q.wdata[3:0];
                    default: st_clr = 4'h0;
                endcase
            end
            unique case (q.aw_idx)
                `TW_IDX_COUNT: d.cnt = merge16(q.cnt, q.wdata, q.wstrb);
                `TW_IDX_CAPTURE: d.cap = merge16(q.cap, q.wdata, q.wstrb);
                `TW_IDX_CMP_A: d.buf_a = merge16(q.buf_a, q.wdata, q.wstrb);
                `TW_IDX_CMP_B: d.buf_b = merge16(q.buf_b, q.wdata, q.wstrb);
                default: d.bresp = d.bresp;
            endcase
        end
        // a new event outlasts a same-cycle clear
        d.status = (q.status & ~st_clr) | st_set;
        unique case (s_axi_araddr[11:2])
            `TW_IDX_CTRL_A: rd_word = {24'h0, q.com_a, q.com_b, 2'h0, q.wgm[1:0]};
            `TW_IDX_CTRL_B: rd_word = {24'h0, q.noise_en, q.edge_sel, 1'b0, q.wgm[3:2], q.cs};
            `TW_IDX_COUNT: rd_word = {16'h0, q.cnt};
            `TW_IDX_CAPTURE: rd_word = {16'h0, q.cap};
            `TW_IDX_CMP_A: rd_word = {16'h0, q.buf_a};
            `TW_IDX_CMP_B: rd_word = {16'h0, q.buf_b};
            `TW_IDX_STATUS: rd_word = {28'h0, q.status};
            `TW_IDX_MASK: rd_word = {28'h0, q.mask};
            `TW_IDX_PORT: rd_word = {28'h0, q.port};
            default: rd_word = 32'h0;
        endcase
        if (s_axi_rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rdata = rd_word;
            d.rresp = hit(s_axi_araddr[11:2]) ? `TW_RESP_OKAY : `TW_RESP_SLVERR;
        end
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

endmodule

// [verification/tw_timer16_chk.sv]
// checker of bus handshake, drive enable and interrupt timing of the waveform timer
module tw_timer16_chk (
    input logic clock,
    input logic rst_b,
    input logic ce,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic wave_out_a_oe_b,
    input logic irq
);
    // ********************************
    // properties
    // ********************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write answer late");
    property p_rh;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rh: assert property (p_rh) else $error("read answer dropped");
    property p_bh;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bh: assert property (p_bh) else $error("write answer dropped");
    property p_rb;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rb: assert property (p_rb) else $error("read taken while busy");
    property p_ce;
        !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready;
    endproperty
    a_ce: assert property (p_ce) else $error("ready while frozen");
    // drive enable moves only with a register write
    property p_oe;
        $changed(wave_out_a_oe_b) |-> $rose(s_axi_bvalid);
    endproperty
    a_oe: assert property (p_oe) else $error("drive enable moved alone");
    property p_irq;
        $fell(irq) |-> $rose(s_axi_bvalid);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt fell without write");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
    c_irq: cover property ($rose(irq));
endmodule

bind tw_timer16 tw_timer16_chk u_chk (
    .clock, .rst_b, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wave_out_a_oe_b, .irq
);

// [verification/tw_timer16_tb.sv]
// self-checking bench of the waveform timer driven over its register bus
module tw_timer16_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = '0, rst_b = '0, ce = '1, capture_pin = '0, ext_clock_pin = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic wave_out_a, wave_out_a_oe_b, wave_out_b, wave_out_b_oe_b;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int n_errors = 0, checked = 0, ta, tgb, hb;
    logic [3:0] tmode [8] = '{4'h4, 4'h1, 4'h5, 4'h9, 4'hB, 4'hD, 4'hE, 4'hF};
    logic [15:0] tog_a = 16'hCA10;
    logic [3:0] dmode [6] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hB, 4'hB};
    logic [1:0] dcom [6] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3};
    logic [31:0] dcmp [6] = '{32'h3, 32'h3, 32'h9, 32'h9, 32'h3, 32'h3};
    int dexp [6] = '{36, 54, 90, 0, 30, 60};
    wire [3:0] pins = {wave_out_b, wave_out_a, wave_out_b_oe_b, wave_out_a_oe_b};

    tw_timer16 dut (.*);

    initial begin
        forever #25 clock = ~clock;
    end

    // ********************************
    // bus tasks and comparisons
    // ********************************
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic limit(input int n);
        if (n >= 50) begin
            n_errors++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic a = 1'h0, w = 1'h0;
        int n = 0;
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(negedge clock);
            a = a | s_axi_awready;
            w = w | s_axi_wready;
            @(posedge clock);
            s_axi_awvalid <= !a;
            s_axi_wvalid <= !w;
        end while (!(a && w) && ++n < 50);
        limit(n);
        n = 0;
        do @(negedge clock); while (s_axi_bvalid !== 1'h1 && ++n < 50);
        limit(n);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge clock);
        s_axi_bready <= 1'h1;
        @(posedge clock);
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er = 2'h0);
        int n = 0;
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        do @(negedge clock); while (s_axi_arready !== 1'h1 && ++n < 50);
        limit(n);
        @(posedge clock);
        s_axi_arvalid <= 1'h0;
        n = 0;
        do @(negedge clock); while (s_axi_rvalid !== 1'h1 && ++n < 50);
        limit(n);
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge clock);
        s_axi_rready <= 1'h1;
        @(posedge clock);
        s_axi_rready <= 1'h0;
    endtask

    task automatic set_mode(input logic [3:0] m, input logic [1:0] ca, input logic [1:0] cb);
        wr(10'h080, {24'h0, ca, cb, 2'h0, m[1:0]});
        wr(10'h081, {27'h0, m[3:2], 3'h1});
        wr(10'h084, 32'h0);
    endtask

    // counts toggles of both pins and high cycles of pin b
    task automatic watch(input int cyc);
        logic pa, pb;
        ta = 0;
        tgb = 0;
        hb = 0;
        @(negedge clock);
        repeat (cyc) begin
            pa = wave_out_a;
            pb = wave_out_b;
            @(negedge clock);
            ta += int'(wave_out_a !== pa);
            tgb += int'(wave_out_b !== pb);
            hb += int'(wave_out_b === 1'h1);
        end
        @(posedge clock);
    endtask

    // ********************************
    // test sequence
    // ********************************
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'h1;
        @(posedge clock);
        rd(10'h080, 32'h0);
        rd(10'h081, 32'h0);
        wr(10'h081, 32'hF8);
        rd(10'h081, 32'hD8);
        wr(10'h080, 32'hFF);
        rd(10'h080, 32'hF3);
        repeat (10) @(posedge clock);
        rd(10'h084, 32'h0);
        rd(10'h07F, 32'h0, 2'h2);
        wr(10'h07F, 32'h1, 2'h2);
        wr(10'h092, 32'h5);
        wr(10'h080, 32'h03);
        chk({28'h0, pins}, 32'h6);
        wr(10'h080, 32'hC3);
        chk({28'h0, pins}, 32'h2);
        $display("test registers and pins done");
        wr(10'h088, 32'h5);
        wr(10'h08A, 32'h2);
        wr(10'h086, 32'h5);
        wr(10'h092, 32'hF);
        foreach (tmode[i]) begin
            set_mode(tmode[i], 2'h1, 2'h1);
            watch(60);
            chk({31'h0, ta > 1}, {31'h0, tog_a[tmode[i]]});
            chk({31'h0, tgb > 1}, {31'h0, tmode[i] == 4'h4});
        end
        $display("test toggle modes done");
        wr(10'h088, 32'h9);
        foreach (dmode[i]) begin
            wr(10'h08A, dcmp[i]);
            set_mode(dmode[i], 2'h0, dcom[i]);
            watch(30);
            watch(90);
            chk({31'h0, hb >= dexp[i] - 8 && hb <= dexp[i] + 8}, 32'h1);
        end
        $display("test pwm duty done");
        wr(10'h081, 32'h0);
        wr(10'h080, 32'h0);
        wr(10'h090, 32'hF);
        wr(10'h091, 32'h1);
        wr(10'h084, 32'hFFF0);
        chk({31'h0, irq}, 32'h0);
        wr(10'h081, 32'h1);
        watch(25);
        chk({31'h0, irq}, 32'h1);
        wr(10'h081, 32'h0);
        wr(10'h091, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(10'h091, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(10'h090, 32'h1);
        chk({31'h0, irq}, 32'h0);
        ce <= 1'h0;
        repeat (3) @(posedge clock);
        ce <= 1'h1;
        @(posedge clock);
        $display("test interrupt done");
        for (int c = 6; c < 8; c++) begin
            wr(10'h081, 32'(c));
            wr(10'h084, 32'h0);
            repeat (3) begin
                ext_clock_pin <= 1'h1;
                repeat (4) @(posedge clock);
                ext_clock_pin <= 1'h0;
                repeat (4) @(posedge clock);
            end
            rd(10'h084, 32'h3);
        end
        $display("test external clock done");
        end_of_test();
    end
endmodule
